// [cdl_defines.svh]
`ifndef CDL_DEFINES_SVH
`define CDL_DEFINES_SVH

// register byte addresses, one aligned word each
`define CDL_A_RAW    8'h04
`define CDL_A_FIN    8'h08
`define CDL_A_OVR    8'h0C
`define CDL_A_LIM1   8'h10
`define CDL_A_LIMB1  8'h14
`define CDL_A_LIMB2  8'h18
`define CDL_A_LIM2   8'h1C
`define CDL_A_TREF   8'h20
`define CDL_A_TRIM   8'h24
`define CDL_A_SEL2   8'h28
`define CDL_A_TRSEL  8'h2C
`define CDL_A_MODE0  8'h30
`define CDL_A_MODE1  8'h34
`define CDL_A_Q1     8'h38
`define CDL_A_Q4     8'h3C
`define CDL_A_Q3     8'h40
`define CDL_A_Q2     8'h44
`define CDL_A_AUTO   8'h48
`define CDL_A_DELAY  8'h4C
`define CDL_A_THR1   8'h50
`define CDL_A_THR2   8'h54
`define CDL_A_SLP1   8'h58
`define CDL_A_SLP2   8'h5C
`define CDL_A_FLG1   8'h60
`define CDL_A_FLG2   8'h64

// reset values
`define CDL_RST_LIM  10'h3E8
`define CDL_RST_TREF 11'h000
`define CDL_RST_TRIM 11'h000
`define CDL_RST_BIT0 1'h0
`define CDL_RST_QUAD 1'h1
`define CDL_RST_DLY  8'h00
`define CDL_RST_SLP  8'h00

// full scale of demand and limits
`define CDL_FULL     20'sh003E8
// slope scaling shift (slope / 128)
`define CDL_SLP_SH   7

// timer: one second in ns and the clock period in ns
`define CDL_SEC_NS   1000000000
`define CDL_CLK_NS   50

// axi responses
`define CDL_OKAY     2'h0
`define CDL_SLVERR   2'h2

`endif

// [cdl_pkg.sv]
package cdl_pkg;
   // control modes in order of the two mode bits {high, low}
   typedef enum logic [1:0] {
      CDL_SPEED,
      CDL_TORQUE,
      CDL_OVERRIDE,
      CDL_COILER
   } cdl_mode_e;

   typedef logic signed [19:0] cdl_wide_t;
   typedef logic [10:0] cdl_dem_t;
   typedef logic [9:0] cdl_lim_t;

   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      cdl_lim_t lim1;
      cdl_lim_t limb1;
      cdl_lim_t limb2;
      cdl_lim_t lim2;
      cdl_lim_t thr1;
      cdl_lim_t thr2;
      logic [7:0] slp1;
      logic [7:0] slp2;
      logic [7:0] delay;
      cdl_dem_t tref;
      cdl_dem_t trim;
      logic sel2;
      logic trsel;
      logic mode0;
      logic mode1;
      logic q1;
      logic q4;
      logic q3;
      logic q2;
      logic auto_en;
      logic run_d;
      logic [31:0] cyc;
      logic [7:0] secs;
      cdl_dem_t raw;
      cdl_dem_t fin;
      cdl_dem_t ovr;
      logic flg1;
      logic flg2;
      logic zref;
   } cdl_state_s;
endpackage

// [cdl_limiter.sv]
// Operation
// RULE_01 - final demand clamped by overriding limit and both bridge limits
// RULE_02 - overriding limit is min of taper result and limit two if chosen
// RULE_03 - limit one caps both bridges and is the taper datum
// RULE_04 - positive demand capped by bridge one, negative by bridge two
// RULE_05 - limit two acts on both bridges when selected
// RULE_06 - signed torque reference register, default zero
// RULE_07 - trim added to demand only when trim select is one
// RULE_08 - limit two select bit, default zero, brings in limit two
// RULE_09 - two mode bits choose speed, torque, override or coiler mode
// RULE_10 - basic torque mode routes torque reference through all limits
// RULE_11 - override mode clamps speed output to torque reference or zero
// RULE_12 - override mode regen quadrants: zero demand below speed demand
// RULE_13 - coiler mode: zero speed reference when torque opposes speed
// RULE_14 - quadrant one enable permits forward motoring
// RULE_15 - quadrant four enable permits reverse regeneration
// RULE_16 - quadrant three enable permits reverse motoring
// RULE_17 - quadrant two enable permits forward regeneration
// RULE_18 - auto change sets limit two select after timer expires in run
// RULE_19 - timer interval 0 to 255 seconds in one second steps
// RULE_20 - taper one flag set when speed exceeds threshold one
// RULE_21 - limit falls with speed above threshold one at slope one
// RULE_22 - software keeps taper one as the lower threshold
// RULE_23 - taper two flag set when speed exceeds threshold two
// RULE_24 - each 8-bit slope applies in both rotation directions
// RULE_25 - timer restarts on run and stays cleared while stopped
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`include "cdl_defines.svh"

module cdl_limiter #(
   parameter int unsigned CYC_PER_SEC = `CDL_SEC_NS / `CDL_CLK_NS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire cdl_pkg::cdl_dem_t speed_loop_out,
   input wire cdl_pkg::cdl_dem_t speed_feedback,
   input wire cdl_pkg::cdl_dem_t speed_error,
   input wire cdl_pkg::cdl_dem_t final_speed_demand,
   input wire logic run_cmd,
   output cdl_pkg::cdl_dem_t final_current_demand,
   output logic zero_speed_ref,
   output logic taper1_exceeded,
   output logic taper2_exceeded,
   output logic limit2_active
);
   import cdl_pkg::*;

   cdl_state_s st_ff;
   cdl_state_s nxt_st;

   // sign extend a demand word into the wide arithmetic type
   function automatic cdl_wide_t sx(input cdl_dem_t x);
      sx = {{9{x[10]}}, x};
   endfunction

   // zero extend a limit word
   function automatic cdl_wide_t zx(input cdl_lim_t x);
      zx = {10'h000, x};
   endfunction

   function automatic cdl_wide_t mn(input cdl_wide_t a, input cdl_wide_t b);
      mn = (a < b) ? a : b;
   endfunction

   function automatic cdl_wide_t mx(input cdl_wide_t a, input cdl_wide_t b);
      mx = (a > b) ? a : b;
   endfunction

   function automatic cdl_wide_t ab(input cdl_wide_t a);
      ab = (a < 0) ? -a : a;
   endfunction

   // saturate to the signed full-scale demand range
   function automatic cdl_dem_t sat(input cdl_wide_t a);
      cdl_wide_t c;
      c = mx(mn(a, `CDL_FULL), -`CDL_FULL);
      sat = c[10:0];
   endfunction

   // limit reduction for one taper; magnitude makes it symmetric
   function automatic cdl_wide_t red(input cdl_wide_t spd,
                                     input cdl_lim_t thr,
                                     input logic [7:0] slp);
      cdl_wide_t d;
      d = spd - zx(thr);
      red = (d > 0) ? ((d * {12'h000, slp}) >>> `CDL_SLP_SH) : '0;
   endfunction

   // byte-lane merge of a write into the old word
   function automatic logic [31:0] mrg(input logic [31:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0] sb);
      logic [31:0] m;
      m = {{8{sb[3]}}, {8{sb[2]}}, {8{sb[1]}}, {8{sb[0]}}};
      mrg = (old & ~m) | (wd & m);
   endfunction

   // readback; signed fields show two's complement in low bits
   function automatic logic [32:0] rd(input cdl_state_s s,
                                     input logic [7:0] a);
      rd = {1'b1, 32'h0000_0000};
      case (a)
         `CDL_A_RAW: rd = {1'b1, 21'h0, s.raw};
         `CDL_A_FIN: rd = {1'b1, 21'h0, s.fin};
         `CDL_A_OVR: rd = {1'b1, 21'h0, s.ovr};
         `CDL_A_LIM1: rd = {1'b1, 22'h0, s.lim1};
         `CDL_A_LIMB1: rd = {1'b1, 22'h0, s.limb1};
         `CDL_A_LIMB2: rd = {1'b1, 22'h0, s.limb2};
         `CDL_A_LIM2: rd = {1'b1, 22'h0, s.lim2};
         `CDL_A_TREF: rd = {1'b1, 21'h0, s.tref};
         `CDL_A_TRIM: rd = {1'b1, 21'h0, s.trim};
         `CDL_A_SEL2: rd = {1'b1, 31'h0, s.sel2};
         `CDL_A_TRSEL: rd = {1'b1, 31'h0, s.trsel};
         `CDL_A_MODE0: rd = {1'b1, 31'h0, s.mode0};
         `CDL_A_MODE1: rd = {1'b1, 31'h0, s.mode1};
         `CDL_A_Q1: rd = {1'b1, 31'h0, s.q1};
         `CDL_A_Q4: rd = {1'b1, 31'h0, s.q4};
         `CDL_A_Q3: rd = {1'b1, 31'h0, s.q3};
         `CDL_A_Q2: rd = {1'b1, 31'h0, s.q2};
         `CDL_A_AUTO: rd = {1'b1, 31'h0, s.auto_en};
         `CDL_A_DELAY: rd = {1'b1, 24'h0, s.delay};
         `CDL_A_THR1: rd = {1'b1, 22'h0, s.thr1};
         `CDL_A_THR2: rd = {1'b1, 22'h0, s.thr2};
         `CDL_A_SLP1: rd = {1'b1, 24'h0, s.slp1};
         `CDL_A_SLP2: rd = {1'b1, 24'h0, s.slp2};
         `CDL_A_FLG1: rd = {1'b1, 31'h0, s.flg1};
         `CDL_A_FLG2: rd = {1'b1, 31'h0, s.flg2};
         default: rd = {1'b0, 32'h0000_0000};
      endcase
   endfunction

   function automatic cdl_state_s rst_val();
      rst_val = '0;
      rst_val.lim1 = `CDL_RST_LIM;
      rst_val.limb1 = `CDL_RST_LIM;
      rst_val.limb2 = `CDL_RST_LIM;
      rst_val.lim2 = `CDL_RST_LIM;
      rst_val.thr1 = `CDL_RST_LIM;
      rst_val.thr2 = `CDL_RST_LIM;
      rst_val.tref = `CDL_RST_TREF;
      rst_val.trim = `CDL_RST_TRIM;
      rst_val.sel2 = `CDL_RST_BIT0;
      rst_val.q1 = `CDL_RST_QUAD;
      rst_val.q4 = `CDL_RST_QUAD;
      rst_val.q3 = `CDL_RST_QUAD;
      rst_val.q2 = `CDL_RST_QUAD;
      rst_val.delay = `CDL_RST_DLY;
      rst_val.slp1 = `CDL_RST_SLP;
      rst_val.slp2 = `CDL_RST_SLP;
   endfunction

   // handshakes: one write and one read in flight
   assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
   assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
   assign s_axi_arready = !st_ff.rvalid;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign final_current_demand = st_ff.fin;
   assign zero_speed_ref = st_ff.zref;
   assign taper1_exceeded = st_ff.flg1;
   assign taper2_exceeded = st_ff.flg2;
   assign limit2_active = st_ff.sel2;

   // datapath and bus slave, one pass per sampling cycle
   always_comb begin
      cdl_mode_e mode;
      cdl_wide_t spd;
      cdl_wide_t slo;
      cdl_wide_t tr;
      cdl_wide_t tap;
      cdl_wide_t ovr;
      cdl_wide_t dem;
      cdl_wide_t rawv;
      cdl_wide_t cap;
      cdl_wide_t finv;
      logic [32:0] rv;
      logic [31:0] wv;
      logic regen;
      logic allow;
      logic tmo;
      mode = cdl_mode_e'({st_ff.mode1, st_ff.mode0});
      spd = ab(sx(speed_feedback));
      slo = sx(speed_loop_out);
      tr = sx(st_ff.tref);
      rv = '0;
      wv = '0;
      tap = '0;
      ovr = '0;
      dem = '0;
      rawv = '0;
      cap = '0;
      finv = '0;
      regen = 1'b0;
      allow = 1'b0;
      tmo = 1'b0;
      nxt_st = st_ff;

      // taper from the limit-one datum, floored at zero
      // RULE_03 limit one datum
      // RULE_21 taper one slope
      // RULE_24 symmetric slopes
      tap = mx(zx(st_ff.lim1) - red(spd, st_ff.thr1, st_ff.slp1)
               - red(spd, st_ff.thr2, st_ff.slp2), '0);
      // RULE_02 overriding limit
      // RULE_05 limit two both bridges
      // RULE_08 select brings limit two
      ovr = st_ff.sel2 ? mn(tap, zx(st_ff.lim2)) : tap;

      // override clamp: speed output held between zero and reference
      // RULE_11 clamp to reference
      if (tr >= 0) begin
         dem = mn(mx(slo, '0), tr);
      end else begin
         dem = mx(mn(slo, '0), tr);
      end
      regen = (tr != 0) && ((sx(speed_feedback) < 0) != (tr < 0));

      // RULE_09 mode select
      case (mode)
         CDL_SPEED: dem = slo;
         // RULE_10 torque reference routed
         // RULE_06 torque reference source
         CDL_TORQUE: dem = tr;
         CDL_OVERRIDE: begin
            // RULE_12 regen below speed demand
            if (regen && spd < ab(sx(final_speed_demand))) begin
               dem = '0;
            end
         end
         CDL_COILER: dem = dem;
         default: dem = slo;
      endcase
      // RULE_13 zero speed reference
      nxt_st.zref = (mode == CDL_COILER) && regen;

      // RULE_07 optional trim
      rawv = sx(sat(dem + (st_ff.trsel ? sx(st_ff.trim) : '0)));

      // RULE_04 per-bridge caps by sign
      // RULE_01 final clamp
      cap = mn(ovr, zx(rawv >= 0 ? st_ff.limb1 : st_ff.limb2));
      finv = mx(mn(rawv, cap), -cap);

      // quadrant from speed sign and demand sign
      if (sx(speed_feedback) >= 0) begin
         // RULE_14 forward motoring
         // RULE_17 forward regeneration
         allow = (finv >= 0) ? st_ff.q1 : st_ff.q2;
      end else begin
         // RULE_16 reverse motoring
         // RULE_15 reverse regeneration
         allow = (finv < 0) ? st_ff.q3 : st_ff.q4;
      end
      nxt_st.raw = rawv[10:0];
      nxt_st.ovr = ovr[10:0];
      nxt_st.fin = allow ? finv[10:0] : 11'h000;

      // RULE_20 taper one flag
      nxt_st.flg1 = spd > zx(st_ff.thr1);
      // RULE_23 taper two flag
      nxt_st.flg2 = spd > zx(st_ff.thr2);

      // seconds timer; stopped drive holds it at zero
      // RULE_25 restart on run
      nxt_st.run_d = run_cmd;
      if (!run_cmd || !st_ff.run_d) begin
         nxt_st.cyc = '0;
         nxt_st.secs = '0;
      end else if (st_ff.cyc == CYC_PER_SEC - 1) begin
         nxt_st.cyc = '0;
         // RULE_19 saturates at 255 s
         if (st_ff.secs != 8'hFF) begin
            nxt_st.secs = st_ff.secs + 8'h01;
         end
      end else begin
         nxt_st.cyc = st_ff.cyc + 32'h0000_0001;
      end
      tmo = run_cmd && st_ff.run_d && st_ff.secs >= st_ff.delay;

      // bus: capture address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.w_got = 1'b1;
         nxt_st.w_data = s_axi_wdata;
         nxt_st.w_strb = s_axi_wstrb;
      end
      if (st_ff.aw_got && st_ff.w_got) begin
         rv = rd(st_ff, st_ff.aw_addr);
         wv = mrg(rv[31:0], st_ff.w_data, st_ff.w_strb);
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = `CDL_OKAY;
         case (st_ff.aw_addr)
            `CDL_A_LIM1: nxt_st.lim1 = wv[9:0];
            `CDL_A_LIMB1: nxt_st.limb1 = wv[9:0];
            `CDL_A_LIMB2: nxt_st.limb2 = wv[9:0];
            `CDL_A_LIM2: nxt_st.lim2 = wv[9:0];
            `CDL_A_TREF: nxt_st.tref = wv[10:0];
            `CDL_A_TRIM: nxt_st.trim = wv[10:0];
            `CDL_A_SEL2: nxt_st.sel2 = wv[0];
            `CDL_A_TRSEL: nxt_st.trsel = wv[0];
            `CDL_A_MODE0: nxt_st.mode0 = wv[0];
            `CDL_A_MODE1: nxt_st.mode1 = wv[0];
            `CDL_A_Q1: nxt_st.q1 = wv[0];
            `CDL_A_Q4: nxt_st.q4 = wv[0];
            `CDL_A_Q3: nxt_st.q3 = wv[0];
            `CDL_A_Q2: nxt_st.q2 = wv[0];
            `CDL_A_AUTO: nxt_st.auto_en = wv[0];
            `CDL_A_DELAY: nxt_st.delay = wv[7:0];
            `CDL_A_THR1: nxt_st.thr1 = wv[9:0];
            `CDL_A_THR2: nxt_st.thr2 = wv[9:0];
            `CDL_A_SLP1: nxt_st.slp1 = wv[7:0];
            `CDL_A_SLP2: nxt_st.slp2 = wv[7:0];
            // read-only and unmapped words refuse writes
            default: nxt_st.bresp = `CDL_SLVERR;
         endcase
      end else if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end

      // automatic select after the write, so the set wins a clear
      // RULE_18 auto limit change
      if (st_ff.auto_en && tmo) begin
         nxt_st.sel2 = 1'b1;
      end

      // read answer one cycle after the address is taken
      if (s_axi_arvalid && s_axi_arready) begin
         rv = rd(st_ff, s_axi_araddr);
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = rv[31:0];
         nxt_st.rresp = rv[32] ? `CDL_OKAY : `CDL_SLVERR;
      end else if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
   end

   // whole state registered at once; synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= rst_val();
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule

// [cdl_speed_loop.sv]
module cdl_speed_loop
   import cdl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire cdl_dem_t fb_tgt,
   input wire cdl_dem_t fd_tgt,
   output cdl_dem_t loop_out,
   output cdl_dem_t fb,
   output cdl_dem_t err,
   output cdl_dem_t fd
);
   timeunit 1ns;
   timeprecision 1ns;
   int e;
   // defined levels before the first edge
   initial begin
      {loop_out, fb, err, fd} = '0;
   end
   // proportional loop, gain 3; saturates at full scale like the real one
   always @(posedge aclk) begin
      e = aresetn ? $signed(fd_tgt) - $signed(fb_tgt) : 0;
      e = e > 1000 ? 1000 : (e < -1000 ? -1000 : e);
      err <= 11'(e);
      e = e * 3;
      loop_out <= 11'(e > 1000 ? 1000 : (e < -1000 ? -1000 : e));
      fb <= aresetn ? fb_tgt : '0;
      fd <= aresetn ? fd_tgt : '0;
   end
endmodule

// [cdl_limiter_checker.sv]
module cdl_limiter_checker
   import cdl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire cdl_dem_t speed_feedback,
   input wire cdl_dem_t final_current_demand,
   input wire logic taper1_exceeded
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // channels idle at the first edge out of reset
   AST_RST_IDLE: // bus reset state
   assert property ($rose(aresetn) |-> s_axi_awready && s_axi_arready
      && !s_axi_bvalid && !s_axi_rvalid) else $error("bus busy after reset");
   // responses hold until taken
   AST_B_HOLD: // write response hold
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   AST_R_HOLD: // read data hold
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   // write answer registers one cycle after both halves are held
   AST_WR_ANSWER: // write answer
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("no write response");
   AST_RD_ANSWER: // read answer
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read data");
   AST_BUSY_REFUSE: // one write at a time
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_FIN_SPAN:
   assert property ($signed(final_current_demand) <= 11'sh3E8
      && $signed(final_current_demand) >= -11'sh3E8)
      else $error("final demand beyond full scale");
   AST_FLAG_SPEED:
   assert property (taper1_exceeded |-> $past(speed_feedback) != 11'h000)
      else $error("taper flag with zero speed");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property (taper1_exceeded);
endmodule

bind cdl_limiter cdl_limiter_checker i_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .speed_feedback(speed_feedback),
   .final_current_demand(final_current_demand),
   .taper1_exceeded(taper1_exceeded));

// [cdl_limiter_test.sv]
module cdl_limiter_test;
   timeunit 1ns;
   timeprecision 1ns;
   import cdl_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0;
   logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdq, rdt;
   logic awr, wrd, bv, arr, rv, t1, t2, zr, l2;
   logic [1:0] br, rr, rsp;
   cdl_dem_t slo, sfb, ser, sfd, fin;
   cdl_dem_t fbt = 11'h001, fdt = 11'h000;
   int n_fail = 0, n_tests = 0, cyc = 0, m, k, i, v;
   int r [4:25];
   logic [31:0] st = 32'h0000_B649;

   always #25 aclk = ~aclk;

   cdl_speed_loop i_spd (.aclk(aclk), .aresetn(aresetn), .fb_tgt(fbt),
      .fd_tgt(fdt), .loop_out(slo), .fb(sfb), .err(ser), .fd(sfd));

   // ten cycles stand for one second so the timer runs briefly
   cdl_limiter #(.CYC_PER_SEC(10)) i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdq), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .speed_loop_out(slo),
      .speed_feedback(sfb), .speed_error(ser), .final_speed_demand(sfd),
      .run_cmd(run), .final_current_demand(fin), .zero_speed_ref(zr),
      .taper1_exceeded(t1), .taper2_exceeded(t2), .limit2_active(l2));

   // xorshift32, fixed seed so every run is identical
   function automatic int unsigned rnd();
      st ^= st << 13;
      st ^= st >> 17;
      st ^= st << 5;
      return st;
   endfunction

   function automatic int rst_val(int k);
      return k inside {4, 5, 6, 7, 20, 21} ? 1000 : int'(k inside {[14:17]});
   endfunction

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %0h seen %0h", n, e, g);
      end
   endtask

   task stop_test();
      if (n_fail == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // bus write; response ready raised with the request, held until answer
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end while ((awv && !awr) || (wv && !wrd));
      do @(posedge aclk); while (!bv);
      rsp = br;
      bry <= 1'b0;
   endtask

   // bus read; data taken at the edge where rvalid is seen with rready
   task automatic rd(logic [7:0] a);
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do @(posedge aclk); while (!arr);
      arv <= 1'b0;
      do @(posedge aclk); while (!rv);
      rdt = rdq;
      rsp = rr;
      rry <= 1'b0;
   endtask

   // integer model of the demand path, fed from the pins it sees
   task automatic model();
      int so, fb, fd, tr, a, rg, src, tp, b, f;
      so = $signed(slo);
      fb = $signed(sfb);
      fd = $signed(sfd);
      tr = r[8];
      a = fb < 0 ? -fb : fb;
      rg = tr != 0 && (fb < 0) != (tr < 0);
      if (m == 1) src = tr;
      else if (m == 0) src = so;
      else src = tr < 0 ? (so > 0 ? 0 : (so < tr ? tr : so))
         : (so < 0 ? 0 : (so > tr ? tr : so));
      if (m == 2 && rg && a < (fd < 0 ? -fd : fd)) src = 0;
      src = src + (r[11] ? r[9] : 0);
      src = src > 1000 ? 1000 : (src < -1000 ? -1000 : src);
      tp = r[4];
      if (a > r[20]) tp -= r[22] * (a - r[20]) >>> 7;
      if (a > r[21]) tp -= r[23] * (a - r[21]) >>> 7;
      tp = tp < 0 ? 0 : tp;
      if (r[10] && r[7] < tp) tp = r[7];
      b = src < 0 ? r[6] : r[5];
      b = b < tp ? b : tp;
      f = src > b ? b : (src < -b ? -b : src);
      if (fb < 0 ? (f < 0 ? !r[16] : !r[15]) : (f < 0 ? !r[17] : !r[14]))
         f = 0;
      chk("final demand", {21'h0, 11'(f)}, {21'h0, fin});
      chk("zero speed ref", 32'(m == 3 && rg), 32'(zr));
      chk("taper flags", {a > r[21], a > r[20]}, {t2, t1});
      chk("limit two", r[10], l2);
   endtask

   // watchdog far above the ~4900 cycles the sequence needs
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         stop_test();
      end
   end

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      for (k = 4; k <= 25; k++) begin
         r[k] = rst_val(k);
         rd(8'(k * 4));
         chk("reset value", r[k], rdt);
      end
      // a hole in the map and a read-only word are refused
      rd(8'h00);
      chk("hole read", 2, rsp);
      wr(8'h04, 32'h5);
      chk("ro write", 2, rsp);
      wr(8'h20, 32'h7FB);
      rd(8'h20);
      chk("torque setpoint", 32'h7FB, rdt);
      // random settings and speeds; trim kept off where its order is open
      for (i = 0; i < 60; i++) begin
         m = rnd() % 4;
         for (k = 4; k <= 23; k++) begin
            if (k inside {4, 5, 6, 7, 20}) r[k] = rnd() % 1001;
            else if (k == 21) r[k] = r[20] + rnd() % (1001 - r[20]);
            else if (k inside {8, 9}) r[k] = int'(rnd() % 2001) - 1000;
            else if (k > 21) r[k] = rnd() % 256;
            else if (k == 11) r[k] = m < 2 && rnd() % 2;
            else if (k == 12 || k == 13) r[k] = m >> (k - 12) & 1;
            else if (k != 18 && k != 19) r[k] = rnd() % 4 != 0;
            if (k != 18 && k != 19) wr(8'(k * 4), r[k] & 32'h7FF);
         end
         v = rnd() % 1000 + 1;
         fbt <= 11'(rnd() % 2 ? v : -v);
         fdt <= 11'(int'(rnd() % 2001) - 1000);
         repeat (6) @(posedge aclk);
         model();
      end
      // auto switch after three ticks; second pass checks the restart
      wr(8'h28, 32'h0);
      wr(8'h4C, 32'h3);
      wr(8'h48, 32'h1);
      repeat (2) begin
         run <= 1'b1;
         repeat (25) @(posedge aclk);
         chk("limit two early", 0, l2);
         repeat (12) @(posedge aclk);
         chk("limit two late", 1, l2);
         run <= 1'b0;
         wr(8'h28, 32'h0);
         repeat (2) @(posedge aclk);
         chk("limit two stopped", 0, l2);
      end
      stop_test();
   end
endmodule
